// [verilog/smc_regs.svh]
// Contract
// - Modem selection changes through the operating mode register, only while in sleep.
// - Spread modem owns a dual-port payload FIFO reached through the common register port.
// - Selecting the spread modem switches the register map to spread meanings.
// - Spreading field accepts 6 to 12, giving 2^value chips per symbol.
// - FEC rate codes 1 to 4 give rates 4/5 to 4/8, overhead 1.25 to 2.
// - Header-less format sends no header; length, rate and CRC set at both ends.
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define SMC_ADDR_FIFO 8'h00
`define SMC_ADDR_OPMODE 8'h04
`define SMC_ADDR_FSTAT 8'h08
`define SMC_ADDR_MC1 8'h0c
`define SMC_ADDR_MC2 8'h10
`define SMC_ADDR_DOPT 8'h14
`define SMC_ADDR_DTHR 8'h18
`define SMC_ADDR_PSTAT 8'h1c
`define SMC_ADDR_FSK_LO 8'h0c
`define SMC_ADDR_FSK_HI 8'h18

// ****************************************
// Fields and reset values
// ****************************************
`define SMC_OPMODE_LR_BIT 7
`define SMC_MODE_SLEEP 3'h0
`define SMC_RST_MODE 3'h0
`define SMC_RST_FEC 3'h1
`define SMC_RST_SPREAD 4'h7
`define SMC_RST_TUNE 3'h3
`define SMC_RST_THR 8'h0a
`define SMC_SPREAD_MIN 4'h6
`define SMC_SPREAD_MAX 4'hc
`define SMC_SF6 4'h6
`define SMC_TUNE_SF6 3'h5
`define SMC_THR_SF6 8'h0c
`define SMC_FEC_MIN 3'h1
`define SMC_FEC_MAX 3'h4
`define SMC_OVH_BASE 4'h4
`define SMC_FIFO_DEPTH 5'h10
`define SMC_RESP_OKAY 2'h0
`define SMC_RESP_SLVERR 2'h2

`endif

// [verilog/smc_pkg.sv]
`include "smc_regs.svh"
`default_nettype none
package smc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC_WR, ST_BRESP, ST_EXEC_RD, ST_RRESP
  } smc_axi_st_t;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_FIFO, SEL_OPMODE, SEL_FSTAT, SEL_MC1, SEL_MC2,
    SEL_DOPT, SEL_DTHR, SEL_PSTAT, SEL_FSK
  } smc_sel_t;

  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [4:0] cnt;
    logic full;
    logic empty;
    logic [7:0] head;
  } smc_fifo_t;

  typedef struct packed {
    smc_axi_st_t st;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [7:0] raddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic lr;
    logic [2:0] mode;
    logic [2:0] fec;
    logic implicit;
    logic [3:0] spread;
    logic [2:0] tune;
    logic [7:0] thr;
    logic [3:0][7:0] fsk;
    logic hdr_on;
  } smc_top_t;

endpackage
`default_nettype wire

// [verilog/smc_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.svh"
module smc_fifo import smc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  output logic full,
  output logic empty,
  output logic [4:0] level,
  output logic [7:0] head
);
  smc_fifo_t s_ff;
  smc_fifo_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (push && !s_ff.full) begin
      nxt_s.mem[s_ff.wp] = push_data;
      nxt_s.wp = s_ff.wp + 4'h1;
    end
    if (pop && !s_ff.empty) begin
      nxt_s.rp = s_ff.rp + 4'h1;
    end
    nxt_s.cnt = s_ff.cnt + 5'((push && !s_ff.full) ? 1 : 0) - 5'((pop && !s_ff.empty) ? 1 : 0);
    nxt_s.full = (nxt_s.cnt == `SMC_FIFO_DEPTH);
    nxt_s.empty = (nxt_s.cnt == 5'h00);
    // Head is kept registered so the modem side sees a clean flop
    nxt_s.head = nxt_s.mem[nxt_s.rp];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
      s_ff.empty <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign full = s_ff.full;
  assign empty = s_ff.empty;
  assign level = s_ff.cnt;
  assign head = s_ff.head;
endmodule
`default_nettype wire

// [verilog/smc_top.sv]
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.svh"
module smc_top import smc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic modem_push,
  input wire logic [7:0] modem_push_data,
  input wire logic modem_pop,
  output logic modem_fifo_full,
  output logic modem_fifo_empty,
  output logic [7:0] modem_fifo_head,
  output logic spread_mode,
  output logic [3:0] spread_code_value,
  output logic [2:0] fec_rate_value,
  output logic tx_header_on
);
  smc_top_t s_ff;
  smc_top_t nxt_s;
  logic fifo_push;
  logic fifo_pop;
  logic [7:0] fifo_data;
  logic host_push;
  logic host_pop;
  logic modem_busy;
  logic f_full;
  logic f_empty;
  logic [4:0] f_level;
  logic [7:0] f_head;
  smc_sel_t wsel;
  smc_sel_t rsel;

  // ****************************************
  // Address decode
  // ****************************************
  function automatic smc_sel_t smc_decode(input logic [7:0] a, input logic lr);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    smc_decode = SEL_NONE;
    if (w == `SMC_ADDR_OPMODE) begin
      smc_decode = SEL_OPMODE;
    end else if (lr) begin
      // Spread map: same offsets take on the modem meanings
      if (w == `SMC_ADDR_FIFO) smc_decode = SEL_FIFO;
      if (w == `SMC_ADDR_FSTAT) smc_decode = SEL_FSTAT;
      if (w == `SMC_ADDR_MC1) smc_decode = SEL_MC1;
      if (w == `SMC_ADDR_MC2) smc_decode = SEL_MC2;
      if (w == `SMC_ADDR_DOPT) smc_decode = SEL_DOPT;
      if (w == `SMC_ADDR_DTHR) smc_decode = SEL_DTHR;
      if (w == `SMC_ADDR_PSTAT) smc_decode = SEL_PSTAT;
    end else if (w >= `SMC_ADDR_FSK_LO && w <= `SMC_ADDR_FSK_HI) begin
      smc_decode = SEL_FSK;
    end
  endfunction

  assign wsel = smc_decode(s_ff.waddr, s_ff.lr);
  assign rsel = smc_decode(s_ff.raddr, s_ff.lr);

  // ****************************************
  // Payload FIFO arbitration
  // ****************************************
  // Modem side never waits; a host FIFO access waits for each cycle that the modem side pushes or pops
  assign modem_busy = s_ff.lr && (modem_push || modem_pop);
  assign host_push = s_ff.st == ST_EXEC_WR && wsel == SEL_FIFO && !modem_busy && s_ff.wstrb0;
  assign host_pop = s_ff.st == ST_EXEC_RD && rsel == SEL_FIFO && !modem_busy;
  assign fifo_push = (s_ff.lr && modem_push) || host_push;
  assign fifo_pop = (s_ff.lr && modem_pop) || host_pop;
  assign fifo_data = modem_busy ? modem_push_data : s_ff.wdata;

  smc_fifo u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(fifo_push),
    .push_data(fifo_data),
    .pop(fifo_pop),
    .full(f_full),
    .empty(f_empty),
    .level(f_level),
    .head(f_head)
  );

  // ****************************************
  // Bus slave and registers
  // ****************************************
  always_comb begin
    logic sf6_ok;
    sf6_ok = 1'b0;
    nxt_s = s_ff;
    if (s_ff.spread == `SMC_SF6) begin
      sf6_ok = s_ff.implicit && s_ff.tune == `SMC_TUNE_SF6 && s_ff.thr == `SMC_THR_SF6;
    end else begin
      sf6_ok = s_ff.tune == `SMC_RST_TUNE && s_ff.thr == `SMC_RST_THR;
    end
    unique case (s_ff.st)
      ST_IDLE: begin
        if (s_ff.awready && s_axi_awvalid) begin
          nxt_s.aw_got = 1'b1;
          nxt_s.waddr = s_axi_awaddr;
        end
        if (s_ff.wready && s_axi_wvalid) begin
          nxt_s.w_got = 1'b1;
          nxt_s.wdata = s_axi_wdata[7:0];
          nxt_s.wstrb0 = s_axi_wstrb[0];
        end
        if (s_ff.arready && s_axi_arvalid) begin
          nxt_s.raddr = s_axi_araddr;
          nxt_s.st = ST_EXEC_RD;
        end else if (nxt_s.aw_got && nxt_s.w_got) begin
          nxt_s.st = ST_EXEC_WR;
        end
      end
      ST_EXEC_WR: begin
        if (!(wsel == SEL_FIFO && modem_busy)) begin
          nxt_s.bresp = `SMC_RESP_OKAY;
          if (s_ff.wstrb0) begin
            unique case (wsel)
              SEL_OPMODE: begin
                nxt_s.mode = s_ff.wdata[2:0];
                // Modem choice only moves while asleep
                if (s_ff.mode == `SMC_MODE_SLEEP) nxt_s.lr = s_ff.wdata[`SMC_OPMODE_LR_BIT];
              end
              SEL_MC1: begin
                if (s_ff.wdata[3:1] >= `SMC_FEC_MIN && s_ff.wdata[3:1] <= `SMC_FEC_MAX) begin
                  nxt_s.fec = s_ff.wdata[3:1];
                end
                nxt_s.implicit = s_ff.wdata[0];
              end
              SEL_MC2: begin
                if (s_ff.wdata[7:4] >= `SMC_SPREAD_MIN &&
                    s_ff.wdata[7:4] <= `SMC_SPREAD_MAX) begin
                  nxt_s.spread = s_ff.wdata[7:4];
                end
              end
              SEL_DOPT: nxt_s.tune = s_ff.wdata[2:0];
              SEL_DTHR: nxt_s.thr = s_ff.wdata;
              SEL_FSK: nxt_s.fsk[2'(s_ff.waddr[4:2] - 3'h3)] = s_ff.wdata;
              SEL_FIFO: if (f_full) nxt_s.bresp = `SMC_RESP_SLVERR;
              SEL_FSTAT, SEL_PSTAT: ;
              SEL_NONE: nxt_s.bresp = `SMC_RESP_SLVERR;
            endcase
          end
          nxt_s.aw_got = 1'b0;
          nxt_s.w_got = 1'b0;
          nxt_s.bvalid = 1'b1;
          nxt_s.st = ST_BRESP;
        end
      end
      ST_BRESP: begin
        if (s_axi_bready) begin
          nxt_s.bvalid = 1'b0;
          nxt_s.st = ST_IDLE;
        end
      end
      ST_EXEC_RD: begin
        if (!(rsel == SEL_FIFO && modem_busy)) begin
          nxt_s.rresp = `SMC_RESP_OKAY;
          nxt_s.rdata = 32'h0;
          unique case (rsel)
            SEL_OPMODE: nxt_s.rdata[7:0] = {s_ff.lr, 4'h0, s_ff.mode};
            SEL_FIFO: begin
              nxt_s.rdata[7:0] = f_head;
              if (f_empty) nxt_s.rresp = `SMC_RESP_SLVERR;
            end
            SEL_FSTAT: nxt_s.rdata[9:0] = {f_full, f_empty, 3'h0, f_level};
            SEL_MC1: nxt_s.rdata[3:0] = {s_ff.fec, s_ff.implicit};
            SEL_MC2: nxt_s.rdata[7:4] = s_ff.spread;
            SEL_DOPT: nxt_s.rdata[2:0] = s_ff.tune;
            SEL_DTHR: nxt_s.rdata[7:0] = s_ff.thr;
            SEL_PSTAT: begin
              nxt_s.rdata[12:0] = 13'(13'h1 << s_ff.spread);
              nxt_s.rdata[16:13] = `SMC_OVH_BASE + {1'b0, s_ff.fec};
              nxt_s.rdata[17] = s_ff.implicit;
              nxt_s.rdata[18] = sf6_ok;
            end
            SEL_FSK: nxt_s.rdata[7:0] = s_ff.fsk[2'(s_ff.raddr[4:2] - 3'h3)];
            SEL_NONE: nxt_s.rresp = `SMC_RESP_SLVERR;
          endcase
          nxt_s.rvalid = 1'b1;
          nxt_s.st = ST_RRESP;
        end
      end
      ST_RRESP: begin
        if (s_axi_rready) begin
          nxt_s.rvalid = 1'b0;
          nxt_s.st = ST_IDLE;
        end
      end
    endcase
    nxt_s.hdr_on = !nxt_s.implicit;
    nxt_s.awready = nxt_s.st == ST_IDLE && !nxt_s.aw_got;
    nxt_s.wready = nxt_s.st == ST_IDLE && !nxt_s.w_got;
    nxt_s.arready = nxt_s.st == ST_IDLE && !nxt_s.aw_got && !nxt_s.w_got;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
      s_ff.st <= ST_IDLE;
      s_ff.mode <= `SMC_RST_MODE;
      s_ff.fec <= `SMC_RST_FEC;
      s_ff.spread <= `SMC_RST_SPREAD;
      s_ff.tune <= `SMC_RST_TUNE;
      s_ff.thr <= `SMC_RST_THR;
      s_ff.hdr_on <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign s_axi_awready = s_ff.awready;
  assign s_axi_wready = s_ff.wready;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = s_ff.arready;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rresp = s_ff.rresp;
  assign s_axi_rdata = s_ff.rdata;
  assign modem_fifo_full = f_full;
  assign modem_fifo_empty = f_empty;
  assign modem_fifo_head = f_head;
  assign spread_mode = s_ff.lr;
  assign spread_code_value = s_ff.spread;
  assign fec_rate_value = s_ff.fec;
  assign tx_header_on = s_ff.hdr_on;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  mode_switch_sleep_a: assert property ($changed(s_ff.lr) |-> $past(s_ff.mode) == `SMC_MODE_SLEEP)
    else $error("modem selection changed outside sleep");
  fifo_owner_a: assert property (!s_ff.lr |=> $stable(f_level) && $stable(f_head))
    else $error("payload FIFO moved while spread modem not selected");
  map_switch_a: assert property ($rose(s_ff.rvalid) && !$past(s_ff.lr) && $past(s_ff.raddr[7:2]) == 6'h0
    |-> s_ff.rresp == `SMC_RESP_SLVERR)
    else $error("FIFO address answered in FSK map");
  spread_range_a: assert property (s_ff.spread >= `SMC_SPREAD_MIN
    && s_ff.spread <= `SMC_SPREAD_MAX)
    else $error("spreading value outside 6 to 12");
  chip_count_a: assert property ($rose(s_ff.rvalid) && $past(rsel) == SEL_PSTAT
    |-> s_ff.rdata[12:0] == 13'(13'h1 << $past(s_ff.spread)))
    else $error("chips per symbol wrong");
  fec_overhead_a: assert property ($rose(s_ff.rvalid) && $past(rsel) == SEL_PSTAT
    |-> s_ff.rdata[16:13] >= 4'h5 && s_ff.rdata[16:13] <= 4'h8)
    else $error("overhead quarters outside 5 to 8");
  header_drop_a: assert property ($rose(s_ff.implicit) |=> !tx_header_on)
    else $error("header still enabled in header-less format");

  spread_enter_c: cover property ($rose(s_ff.lr));
  host_fifo_c: cover property (host_push ##[1:40] host_pop);
  sf6_setup_c: cover property (s_ff.spread == `SMC_SF6 && s_ff.implicit && s_ff.thr == `SMC_THR_SF6);
endmodule
`default_nettype wire

// [verif/smc_modem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module smc_modem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push_go,
  input wire logic pop_go,
  input wire logic [7:0] byte_in,
  output logic modem_push,
  output logic [7:0] modem_push_data,
  output logic modem_pop
);
  // ****************************************
  // Payload side of the modem buffer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modem_push <= 1'b0;
      modem_pop <= 1'b0;
      modem_push_data <= 8'h00;
    end else begin
      modem_push <= push_go;
      modem_pop <= pop_go;
      // Idle data toggles so a late sample never matches by luck
      modem_push_data <= push_go ? byte_in : ~modem_push_data;
    end
  end
endmodule
`default_nettype wire

// [verif/tb_spread_modem_parameter_config.sv]
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.svh"
module tb_spread_modem_parameter_config;
  localparam logic [7:0] a_ff = `SMC_ADDR_FIFO;
  localparam logic [7:0] a_op = `SMC_ADDR_OPMODE;
  localparam logic [7:0] a_fs = `SMC_ADDR_FSTAT;
  localparam logic [7:0] a_m1 = `SMC_ADDR_MC1;
  localparam logic [7:0] a_m2 = `SMC_ADDR_MC2;
  localparam logic [7:0] a_do = `SMC_ADDR_DOPT;
  localparam logic [7:0] a_dt = `SMC_ADDR_DTHR;
  localparam logic [7:0] a_ps = `SMC_ADDR_PSTAT;
  localparam logic [1:0] ok = `SMC_RESP_OKAY;
  localparam logic [1:0] se = `SMC_RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, pb = 8'h00;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, pg = 1'b0, qg = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'h0;
  logic awr, wr_r, bv, arr, rv, mp, mq, ff, fe, sm, hd;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  logic [7:0] mpd, fh;
  logic [3:0] sfv;
  logic [2:0] fv;
  int num_errors = 0;
  int total_checks = 0;

  initial begin
    forever #50 aclk = ~aclk;
  end

  // Whole run needs well under 3000 cycles
  initial begin
    repeat (6000) @(posedge aclk);
    num_errors++;
    close_out();
  end

  smc_modem_model smc_modem_model_inst (.aclk(aclk), .aresetn(aresetn), .push_go(pg),
    .pop_go(qg), .byte_in(pb), .modem_push(mp), .modem_push_data(mpd), .modem_pop(mq));

  smc_top smc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .modem_push(mp), .modem_push_data(mpd), .modem_pop(mq), .modem_fifo_full(ff),
    .modem_fifo_empty(fe), .modem_fifo_head(fh), .spread_mode(sm),
    .spread_code_value(sfv), .fec_rate_value(fv), .tx_header_on(hd));

  task automatic close_out;
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    ws <= 4'hf;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awr) begin
        ta = 1'b1;
        awv <= 1'b0;
      end
      if (!tw && wr_r) begin
        tw = 1'b1;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1) @(posedge aclk);
    chk("bresp", 32'(er), 32'(br));
    bry <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge aclk);
    d = rdat;
    chk("rresp", 32'(er), 32'(rr));
    rry <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic mq_go(input logic push, input logic [7:0] b);
    @(posedge aclk);
    pg <= push;
    qg <= !push;
    pb <= b;
    @(posedge aclk);
    pg <= 1'b0;
    qg <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic t_reset;
    chk("spread_mode", 32'h0, 32'(sm));
    chk("spread_code", 32'(`SMC_RST_SPREAD), 32'(sfv));
    chk("fec_rate", 32'(`SMC_RST_FEC), 32'(fv));
    chk("header_on", 32'h1, 32'(hd));
    mq_go(1'b1, 8'h11);
    chk("fsk_push_empty", 32'h1, 32'(fe));
  endtask

  task automatic t_select;
    logic [31:0] d;
    rd(a_ps, se, d);
    rd(a_ff, se, d);
    chk("fsk_fifo_data", 32'h0, d);
    wr(a_m1, 32'h5a, ok);
    rd(a_m1, ok, d);
    chk("fsk_scratch", 32'h5a, d);
    wr(8'h20, 32'h1, se);
    rd(8'h20, se, d);
    wr(a_op, 32'h01, ok);
    wr(a_op, 32'h81, ok);
    chk("spread_mode", 32'h0, 32'(sm));
    rd(a_op, ok, d);
    chk("opmode", 32'h01, d);
    wr(a_op, 32'h00, ok);
    wr(a_op, 32'h80, ok);
    chk("spread_mode", 32'h1, 32'(sm));
    rd(a_m1, ok, d);
    chk("mc1_reset", 32'h02, d);
  endtask

  task automatic t_spread;
    logic [31:0] d;
    for (int s = 6; s <= 12; s++) begin
      wr(a_m2, 32'(s << 4), ok);
      chk("spread_code", 32'(s), 32'(sfv));
      rd(a_ps, ok, d);
      chk("chips", 32'h1 << s, 32'(d[12:0]));
    end
    wr(a_m2, 32'hd0, ok);
    chk("spread_above", 32'hc, 32'(sfv));
    wr(a_m2, 32'h50, ok);
    chk("spread_below", 32'hc, 32'(sfv));
    rd(a_m2, ok, d);
    chk("mc2_read", 32'hc0, d);
  endtask

  task automatic t_fec;
    logic [31:0] d;
    for (int c = 1; c <= 4; c++) begin
      wr(a_m1, 32'(c << 1), ok);
      chk("fec_rate", 32'(c), 32'(fv));
      rd(a_ps, ok, d);
      chk("overhead", 32'(4 + c), 32'(d[16:13]));
    end
    wr(a_m1, 32'h0, ok);
    chk("fec_bad", 32'h4, 32'(fv));
  endtask

  task automatic t_sf6;
    logic [31:0] d;
    wr(a_m2, 32'h60, ok);
    wr(a_m1, 32'h03, ok);
    wr(a_do, 32'(`SMC_TUNE_SF6), ok);
    wr(a_dt, 32'(`SMC_THR_SF6), ok);
    chk("header_on", 32'h0, 32'(hd));
    rd(a_ps, ok, d);
    chk("headerless", 32'h1, 32'(d[17]));
    chk("sf6_ok", 32'h1, 32'(d[18]));
    wr(a_dt, 32'(`SMC_RST_THR), ok);
    rd(a_ps, ok, d);
    chk("sf6_bad_thr", 32'h0, 32'(d[18]));
    wr(a_m2, 32'h70, ok);
    wr(a_do, 32'(`SMC_RST_TUNE), ok);
    wr(a_m1, 32'h02, ok);
    chk("header_on", 32'h1, 32'(hd));
    rd(a_ps, ok, d);
    chk("defaults_ok", 32'h1, 32'(d[18]));
  endtask

  task automatic t_fifo;
    logic [31:0] d;
    mq_go(1'b1, 8'haa);
    mq_go(1'b1, 8'h55);
    chk("head", 32'haa, 32'(fh));
    rd(a_fs, ok, d);
    chk("level", 32'h2, 32'(d[4:0]));
    rd(a_ff, ok, d);
    chk("host_pop", 32'haa, d);
    wr(a_ff, 32'h3c, ok);
    mq_go(1'b0, 8'h00);
    chk("head", 32'h3c, 32'(fh));
    mq_go(1'b0, 8'h00);
    chk("empty", 32'h1, 32'(fe));
    rd(a_ff, se, d);
    for (int i = 0; i < 16; i++) mq_go(1'b1, 8'(i));
    chk("full", 32'h1, 32'(ff));
    rd(a_fs, ok, d);
    chk("full_bit", 32'h1, 32'(d[9]));
    wr(a_ff, 32'h77, se);
    for (int i = 0; i < 16; i++) mq_go(1'b0, 8'h00);
    chk("drained", 32'h1, 32'(fe));
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_select();
    t_spread();
    t_fec();
    t_sf6();
    t_fifo();
    close_out();
  end
endmodule
`default_nettype wire
